// ==== hdl/drs_register_stack.sv ====
/*
 * register stack: two general banks, floating registers, working registers,
 * relocation register, with registered read ports and a floating request port
 * assumes the execution control supplies register numbers from instruction fields
 */
`timescale 1ns/1ns
`default_nettype none
// What this block does
// [RULE_01] two general banks of sixteen registers
// [RULE_02] mode picks bank, nothing saved or reloaded
// [RULE_03] general registers are 32 bits wide
// [RULE_04] four bit index 0 to F
// [RULE_05] general registers reached only by instruction fields
// [RULE_06] four doubleword floating registers, numbers 0,2,4,6
// [RULE_07] long uses both words, short first only
// [RULE_08] odd floating number raises program exception
// [RULE_09] working registers hidden from user programs
// [RULE_10] one relocation register for processor and channels
// [RULE_11] fixed point is two's complement, sign leads
// [RULE_12] halfword load sign extends to 32 bits
// [RULE_13] doubleword fixed operand in even-odd pair
// [RULE_14] storage operands aligned to own length
// [RULE_15] floating operands are sign and magnitude
// [RULE_16] exponent excess 64, base sixteen fraction
// [RULE_17] sign bit 0, exponent 1-7, fraction after
// [RULE_18] load, arithmetic, compare, store, sign control supported; the stack has no arithmetic op, only normalize writeback
// [RULE_19] shift one digit left, exponent minus one
// [RULE_20] zero fraction is never shifted
// [RULE_21] problem register mode selects user bank
// [RULE_22] odd number suppresses, floating registers unchanged
module drs_register_stack (
	input  wire logic                            CLK,
	input  wire logic                            RST,
	input  wire logic                            PROBLEM_MODE,
	input  wire logic [drs_pkg::GR_IDX_W-1:0]    GR_RA_IDX,
	input  wire logic [drs_pkg::GR_IDX_W-1:0]    GR_RB_IDX,
	input  wire drs_pkg::drs_gr_wr_t             GR_WR,
	output logic [drs_pkg::WORD_W-1:0]           GR_RA_DATA,
	output logic [drs_pkg::WORD_W-1:0]           GR_RB_DATA,
	output logic [drs_pkg::DWORD_W-1:0]          GR_PAIR_DATA,
	input  wire drs_pkg::drs_fp_req_t            FP_REQ,
	output drs_pkg::drs_fp_rsp_t                 FP_RSP,
	output logic                                 FP_BUSY,
	output logic                                 PGM_EXC,
	input  wire logic                            WK_WE,
	input  wire logic [drs_pkg::WK_IDX_W-1:0]    WK_IDX,
	input  wire logic [drs_pkg::DWORD_W-1:0]     WK_WDATA,
	output logic [drs_pkg::DWORD_W-1:0]          WK_RDATA,
	input  wire logic                            RELOC_WE,
	input  wire logic [drs_pkg::RELOC_W-1:0]     RELOC_WDATA,
	output logic [drs_pkg::RELOC_W-1:0]          RELOC_CPU,
	output logic [drs_pkg::RELOC_W-1:0]          RELOC_CHAN
);
	typedef enum logic {FS_IDLE, FS_NORM} drs_fp_state_t;

	////////////////////////////////////////////////////////////////////////////
	// helpers

	function automatic logic [drs_pkg::WORD_W-1:0] sext_half(input logic [drs_pkg::HALF_W-1:0] h); // RULE_11
		sext_half = {{(drs_pkg::WORD_W-drs_pkg::HALF_W){h[drs_pkg::HALF_W-1]}}, h};
	endfunction

	// magnitude as exponent then fraction; short ignores the second word
	function automatic logic [drs_pkg::FP_SIGN_BIT-1:0] fp_mag(input logic [drs_pkg::DWORD_W-1:0] v,
		input logic lng);
		fp_mag = lng ? v[drs_pkg::FP_EXP_HI:0]
			: {v[drs_pkg::FP_EXP_HI:drs_pkg::FP_SHORT_LO], {drs_pkg::FP_SHORT_LO{1'b0}}};
	endfunction

	function automatic logic fp_zero(input logic [drs_pkg::DWORD_W-1:0] v, input logic lng);
		logic [drs_pkg::FP_SIGN_BIT-1:0] m;
		m = fp_mag(v, lng);
		fp_zero = (m[drs_pkg::FP_FRAC_HI:0] == '0);
	endfunction

	function automatic logic [1:0] fp_cmp(input logic [drs_pkg::DWORD_W-1:0] a,
		input logic [drs_pkg::DWORD_W-1:0] b, input logic lng);
		logic za;
		logic zb;
		logic sa;
		logic sb;
		logic [drs_pkg::FP_SIGN_BIT-1:0] ma;
		logic [drs_pkg::FP_SIGN_BIT-1:0] mb;
		za = fp_zero(a, lng);
		zb = fp_zero(b, lng);
		sa = a[drs_pkg::FP_SIGN_BIT] && !za;
		sb = b[drs_pkg::FP_SIGN_BIT] && !zb;
		ma = za ? '0 : fp_mag(a, lng);
		mb = zb ? '0 : fp_mag(b, lng);
		if (sa != sb) begin
			fp_cmp = sa ? drs_pkg::CC_LOW : drs_pkg::CC_HIGH; // RULE_15
		end else if (ma == mb) begin
			fp_cmp = drs_pkg::CC_EQ;
		end else if ((ma > mb) != sa) begin // RULE_16
			fp_cmp = drs_pkg::CC_HIGH;
		end else begin
			fp_cmp = drs_pkg::CC_LOW;
		end
	endfunction

	////////////////////////////////////////////////////////////////////////////
	// general register banks

	logic [drs_pkg::GR_BANKS-1:0][drs_pkg::GR_COUNT-1:0][drs_pkg::WORD_W-1:0] gr_q; // RULE_01
	logic                           bank; // RULE_02
	logic [drs_pkg::GR_IDX_W-1:0]   wr_even;
	logic [drs_pkg::GR_IDX_W-1:0]   wr_odd;
	logic [drs_pkg::GR_IDX_W-1:0]   ra_even;
	logic [drs_pkg::WORD_W-1:0]     ra_sel;

	assign bank    = PROBLEM_MODE; // RULE_21
	assign wr_even = {GR_WR.idx[drs_pkg::GR_IDX_W-1:1], 1'b0};
	assign wr_odd  = {GR_WR.idx[drs_pkg::GR_IDX_W-1:1], 1'b1};
	assign ra_even = {GR_RA_IDX[drs_pkg::GR_IDX_W-1:1], 1'b0};
	assign ra_sel  = gr_q[bank][GR_RA_IDX];

	always_ff @(posedge CLK) begin
		if (RST) begin
			gr_q <= '0;
		end else if (GR_WR.en) begin
			case (GR_WR.fmt)
				drs_pkg::GW_HALF: begin
					gr_q[bank][GR_WR.idx] <= sext_half(GR_WR.data[drs_pkg::HALF_W-1:0]); // RULE_12
				end
				drs_pkg::GW_DOUBLE: begin
					gr_q[bank][wr_even] <= GR_WR.data[drs_pkg::DWORD_W-1:drs_pkg::WORD_W]; // RULE_13
					gr_q[bank][wr_odd]  <= GR_WR.data[drs_pkg::WORD_W-1:0]; // RULE_13
				end
				default: begin
					gr_q[bank][GR_WR.idx] <= GR_WR.data[drs_pkg::WORD_W-1:0]; // RULE_03
				end
			endcase
		end
	end

	// reads come only from the instruction register-number fields
	always_ff @(posedge CLK) begin
		if (RST) begin
			GR_RA_DATA   <= drs_pkg::GR_RESET;
			GR_RB_DATA   <= drs_pkg::GR_RESET;
			GR_PAIR_DATA <= '0;
		end else begin
			GR_RA_DATA   <= ra_sel; // RULE_05
			GR_RB_DATA   <= gr_q[bank][GR_RB_IDX]; // RULE_04
			GR_PAIR_DATA <= {gr_q[bank][ra_even], gr_q[bank][ra_even | 4'h1]}; // RULE_13
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// working and relocation registers

	logic [drs_pkg::DWORD_W-1:0] wk_q [drs_pkg::WK_COUNT];

	// only the microprogram port reaches these
	always_ff @(posedge CLK) begin
		if (WK_WE) begin
			wk_q[WK_IDX] <= WK_WDATA; // RULE_09
		end
	end

	always_ff @(posedge CLK) begin
		if (RST) begin
			WK_RDATA <= '0;
		end else begin
			WK_RDATA <= wk_q[WK_IDX]; // RULE_09
		end
	end

	always_ff @(posedge CLK) begin
		if (RST) begin
			RELOC_CPU  <= drs_pkg::RELOC_RESET;
			RELOC_CHAN <= drs_pkg::RELOC_RESET;
		end else if (RELOC_WE) begin
			RELOC_CPU  <= RELOC_WDATA; // RULE_10
			RELOC_CHAN <= RELOC_WDATA; // RULE_10
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// floating registers and request handling

	logic [drs_pkg::FP_COUNT-1:0][drs_pkg::DWORD_W-1:0] fp_q;
	drs_fp_state_t                 st_q;
	logic                          take;
	logic                          odd;
	logic [1:0]                    slot;
	logic                          norm_start;
	logic                          norm_done;
	logic [drs_pkg::FP_FRAC_W-1:0] norm_frac;
	logic [drs_pkg::FP_EXP_W-1:0]  norm_exp;
	logic [drs_pkg::FP_FRAC_W-1:0] norm_in;
	logic [1:0]                    pend_slot_q;
	logic                          pend_long_q;
	logic                          pend_sign_q;
	logic                          ld_en;
	logic [drs_pkg::DWORD_W-1:0]   ld_val;
	logic [drs_pkg::DWORD_W-1:0]   wb_val;

	assign take       = FP_REQ.valid && (st_q == FS_IDLE);
	assign odd        = FP_REQ.num[0];
	assign slot       = FP_REQ.num[drs_pkg::FP_NUM_W-1:1]; // RULE_06
	assign norm_start = take && !odd && (FP_REQ.op == drs_pkg::FO_NORM_WB);
	assign norm_in    = FP_REQ.long_fmt ? FP_REQ.data[drs_pkg::FP_FRAC_HI:0]
		: {FP_REQ.data[drs_pkg::FP_FRAC_HI:drs_pkg::FP_SHORT_LO], {drs_pkg::FP_SHORT_LO{1'b0}}};
	assign wb_val     = {pend_sign_q, norm_exp, norm_frac}; // RULE_17

	always_comb begin
		ld_en  = take && !odd; // RULE_22
		ld_val = FP_REQ.data;
		case (FP_REQ.op)
			drs_pkg::FO_LOAD:  ld_val = FP_REQ.data;
			drs_pkg::FO_LPOS:  ld_val[drs_pkg::FP_SIGN_BIT] = 1'b0; // RULE_18
			drs_pkg::FO_LNEG:  ld_val[drs_pkg::FP_SIGN_BIT] = 1'b1; // RULE_18
			drs_pkg::FO_LCOMP: ld_val[drs_pkg::FP_SIGN_BIT] = ~FP_REQ.data[drs_pkg::FP_SIGN_BIT]; // RULE_18
			default:           ld_en = 1'b0;
		endcase
	end

	drs_normalizer u_norm (
		.clk      (CLK),
		.rst      (RST),
		.start    (norm_start),
		.frac_in  (norm_in),
		.exp_in   (FP_REQ.data[drs_pkg::FP_EXP_HI:drs_pkg::FP_EXP_LO]),
		.done     (norm_done),
		.frac_out (norm_frac),
		.exp_out  (norm_exp)
	);

	always_ff @(posedge CLK) begin
		if (RST) begin
			fp_q <= '0;
		end else if (norm_done) begin
			if (pend_long_q) begin
				fp_q[pend_slot_q] <= wb_val; // RULE_07
			end else begin
				fp_q[pend_slot_q][drs_pkg::DWORD_W-1:drs_pkg::FP_SHORT_LO] <=
					wb_val[drs_pkg::DWORD_W-1:drs_pkg::FP_SHORT_LO]; // RULE_07
			end
		end else if (ld_en) begin
			if (FP_REQ.long_fmt) begin
				fp_q[slot] <= ld_val; // RULE_07
			end else begin
				fp_q[slot][drs_pkg::DWORD_W-1:drs_pkg::FP_SHORT_LO] <=
					ld_val[drs_pkg::DWORD_W-1:drs_pkg::FP_SHORT_LO]; // RULE_07
			end
		end
	end

	always_ff @(posedge CLK) begin
		if (RST) begin
			st_q        <= FS_IDLE;
			pend_slot_q <= 2'h0;
			pend_long_q <= 1'b0;
			pend_sign_q <= 1'b0;
			FP_BUSY     <= 1'b0;
		end else begin
			case (st_q)
				FS_IDLE: begin
					if (norm_start) begin
						st_q        <= FS_NORM;
						pend_slot_q <= slot;
						pend_long_q <= FP_REQ.long_fmt;
						pend_sign_q <= FP_REQ.data[drs_pkg::FP_SIGN_BIT];
						FP_BUSY     <= 1'b1;
					end
				end
				default: begin
					if (norm_done) begin
						st_q    <= FS_IDLE;
						FP_BUSY <= 1'b0;
					end
				end
			endcase
		end
	end

	always_ff @(posedge CLK) begin
		if (RST) begin
			FP_RSP  <= '0;
			PGM_EXC <= 1'b0;
		end else begin
			PGM_EXC     <= take && odd; // RULE_08
			FP_RSP.done <= (take && (odd || FP_REQ.op != drs_pkg::FO_NORM_WB)) || norm_done;
			FP_RSP.cc   <= drs_pkg::CC_EQ;
			FP_RSP.data <= '0;
			if (take && !odd && FP_REQ.op == drs_pkg::FO_STORE) begin
				FP_RSP.data <= fp_q[slot]; // RULE_18
			end
			if (take && !odd && FP_REQ.op == drs_pkg::FO_COMPARE) begin
				FP_RSP.cc <= fp_cmp(fp_q[slot], FP_REQ.data, FP_REQ.long_fmt); // RULE_18
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// checks

	logic [drs_pkg::FP_COUNT*drs_pkg::WORD_W-1:0] fp_low;

	always_comb begin
		fp_low = '0;
		for (int i = 0; i < drs_pkg::FP_COUNT; i++) begin
			fp_low[i*drs_pkg::WORD_W +: drs_pkg::WORD_W] = fp_q[i][drs_pkg::WORD_W-1:0];
		end
	end

	property p_odd_exc;
		@(posedge CLK) disable iff (RST) take && odd |=> PGM_EXC && FP_RSP.done ##1 !PGM_EXC;
	endproperty
	a_odd_exc: assert property (p_odd_exc) else $error("odd register gave no exception pulse"); // RULE_08

	property p_even_no_exc;
		@(posedge CLK) disable iff (RST) !(take && odd) |=> !PGM_EXC;
	endproperty
	a_even_no_exc: assert property (p_even_no_exc) else $error("exception without odd register"); // RULE_08

	property p_odd_suppress;
		@(posedge CLK) disable iff (RST) take && odd && !norm_done |=> $stable(fp_q);
	endproperty
	a_odd_suppress: assert property (p_odd_suppress) else $error("odd register request changed a register"); // RULE_22

	property p_short_keeps_low;
		@(posedge CLK) disable iff (RST) take && !FP_REQ.long_fmt && !norm_done && !(FS_NORM == st_q) |=> $stable(fp_low);
	endproperty
	a_short_keeps_low: assert property (p_short_keeps_low) else $error("short operation changed second word"); // RULE_07

	property p_half_sext;
		@(posedge CLK) disable iff (RST) GR_WR.en && GR_WR.fmt == drs_pkg::GW_HALF
			|=> gr_q[$past(bank)][$past(GR_WR.idx)] == sext_half($past(GR_WR.data[drs_pkg::HALF_W-1:0]));
	endproperty
	a_half_sext: assert property (p_half_sext) else $error("halfword not sign extended"); // RULE_12

	property p_bank_isolate;
		@(posedge CLK) disable iff (RST) !PROBLEM_MODE |=> $stable(gr_q[1]);
	endproperty
	a_bank_isolate: assert property (p_bank_isolate) else $error("supervisor write reached user bank"); // RULE_02

	property p_pair_write;
		@(posedge CLK) disable iff (RST) GR_WR.en && GR_WR.fmt == drs_pkg::GW_DOUBLE
			|=> gr_q[$past(bank)][$past(wr_even)] == $past(GR_WR.data[drs_pkg::DWORD_W-1:drs_pkg::WORD_W]);
	endproperty
	a_pair_write: assert property (p_pair_write) else $error("even register of pair not written"); // RULE_13

	property p_read_port;
		@(posedge CLK) disable iff (RST) 1'b1 |=> GR_RA_DATA == $past(gr_q[PROBLEM_MODE][GR_RA_IDX]);
	endproperty
	a_read_port: assert property (p_read_port) else $error("read port returned wrong register"); // RULE_04

	property p_reloc_shared;
		@(posedge CLK) disable iff (RST) RELOC_WE |=> RELOC_CPU == $past(RELOC_WDATA) && RELOC_CHAN == RELOC_CPU;
	endproperty
	a_reloc_shared: assert property (p_reloc_shared) else $error("relocation copies disagree"); // RULE_10

	property p_norm_busy;
		@(posedge CLK) disable iff (RST) norm_start |=> FP_BUSY [*1] ##[1:15] FP_RSP.done;
	endproperty
	a_norm_busy: assert property (p_norm_busy) else $error("normalize writeback not answered"); // RULE_19
endmodule
`default_nettype wire

// ==== hdl/drs_pkg.sv ====
/*
 * constants, formats and carrier types of the dual bank register stack
 * assumes one 125 MHz clock and a microprogrammed execution control as partner
 */
package drs_pkg;
	localparam int GR_BANKS     = 2;
	localparam int GR_COUNT     = 16;
	localparam int GR_IDX_W     = 4;
	localparam int WORD_W       = 32;
	localparam int DWORD_W      = 64;
	localparam int HALF_W       = 16;
	localparam int FP_COUNT     = 4;
	localparam int FP_NUM_W     = 3;
	localparam int WK_COUNT     = 8;
	localparam int WK_IDX_W     = 3;
	localparam int RELOC_W      = 32;
	// floating word layout, bit 63 of the word is the msb here
	localparam int FP_SIGN_BIT  = 63;
	localparam int FP_EXP_HI    = 62;
	localparam int FP_EXP_LO    = 56;
	localparam int FP_EXP_W     = 7;
	localparam int FP_FRAC_HI   = 55;
	localparam int FP_FRAC_W    = 56;
	localparam int FP_SHORT_LO  = 32;
	localparam int FP_DIGIT_W   = 4;
	localparam logic [6:0] FP_EXP_BIAS = 7'h40;
	localparam logic [WORD_W-1:0]  GR_RESET    = 32'h0000_0000;
	localparam logic [DWORD_W-1:0] FP_RESET    = 64'h0000_0000_0000_0000;
	localparam logic [RELOC_W-1:0] RELOC_RESET = 32'h0000_0000;
	localparam logic [1:0] CC_EQ   = 2'h0;
	localparam logic [1:0] CC_LOW  = 2'h1;
	localparam logic [1:0] CC_HIGH = 2'h2;

	typedef enum logic [1:0] {GW_FULL, GW_HALF, GW_DOUBLE} drs_gr_fmt_t;
	typedef enum logic [2:0] {FO_LOAD, FO_STORE, FO_LPOS, FO_LNEG, FO_LCOMP, FO_COMPARE, FO_NORM_WB} drs_fp_op_t;

	typedef struct packed {
		logic                en;
		drs_gr_fmt_t         fmt;
		logic [GR_IDX_W-1:0] idx;
		logic [DWORD_W-1:0]  data;
	} drs_gr_wr_t;

	typedef struct packed {
		logic                valid;
		drs_fp_op_t          op;
		logic                long_fmt;
		logic [FP_NUM_W-1:0] num;
		logic [DWORD_W-1:0]  data;
	} drs_fp_req_t;

	typedef struct packed {
		logic               done;
		logic [1:0]         cc;
		logic [DWORD_W-1:0] data;
	} drs_fp_rsp_t;
endpackage

// ==== hdl/drs_normalizer.sv ====
/*
 * hexadecimal fraction normalizer, one digit shifted per clock
 * assumes start is a single cycle pulse while idle
 */
`timescale 1ns/1ns
`default_nettype none
module drs_normalizer (
	input  wire logic                          clk,
	input  wire logic                          rst,
	input  wire logic                          start,
	input  wire logic [drs_pkg::FP_FRAC_W-1:0] frac_in,
	input  wire logic [drs_pkg::FP_EXP_W-1:0]  exp_in,
	output logic                               done,
	output logic [drs_pkg::FP_FRAC_W-1:0]      frac_out,
	output logic [drs_pkg::FP_EXP_W-1:0]       exp_out
);
	logic [drs_pkg::FP_FRAC_W-1:0] frac_q;
	logic [drs_pkg::FP_EXP_W-1:0]  exp_q;
	logic                          run_q;
	logic                          done_q;
	logic                          stop;

	assign stop     = (frac_q == '0) || (frac_q[drs_pkg::FP_FRAC_W-1 -: drs_pkg::FP_DIGIT_W] != '0);
	assign done     = done_q;
	assign frac_out = frac_q;
	assign exp_out  = exp_q;

	always_ff @(posedge clk) begin
		if (rst) begin
			run_q  <= 1'b0;
			done_q <= 1'b0;
			frac_q <= '0;
			exp_q  <= '0;
		end else begin
			done_q <= 1'b0;
			if (start) begin
				frac_q <= frac_in;
				exp_q  <= exp_in;
				run_q  <= 1'b1;
			end else if (run_q) begin
				if (stop) begin // RULE_20
					run_q  <= 1'b0;
					done_q <= 1'b1;
				end else begin
					frac_q <= {frac_q[drs_pkg::FP_FRAC_W-drs_pkg::FP_DIGIT_W-1:0],
						{drs_pkg::FP_DIGIT_W{1'b0}}}; // RULE_19
					exp_q  <= exp_q - 7'h01; // RULE_19
				end
			end
		end
	end

	property p_norm_step;
		@(posedge clk) disable iff (rst) run_q && !stop && !start |=> exp_q == $past(exp_q) - 7'h01;
	endproperty
	a_norm_step: assert property (p_norm_step) else $error("exponent not reduced by one per shift"); // RULE_19

	property p_norm_zero;
		@(posedge clk) disable iff (rst) start && frac_in == '0 |-> ##2 (done && frac_q == '0 && exp_q == $past(exp_in, 2));
	endproperty
	a_norm_zero: assert property (p_norm_zero) else $error("zero fraction was shifted"); // RULE_20

	property p_norm_bound;
		@(posedge clk) disable iff (rst) start |-> ##[2:15] done;
	endproperty
	a_norm_bound: assert property (p_norm_bound) else $error("normalization did not finish in time"); // RULE_19

	property p_norm_lead;
		@(posedge clk) disable iff (rst) done && frac_q != '0 |-> frac_q[drs_pkg::FP_FRAC_HI -: drs_pkg::FP_DIGIT_W] != '0;
	endproperty
	a_norm_lead: assert property (p_norm_lead) else $error("result leading digit is zero"); // RULE_19
endmodule
`default_nettype wire

// ==== sim/drs_exec_model.sv ====
/*
 * execution control model: issues floating requests, one at a time, and counts program exceptions
 * assumes the bench calls issue on its falling-edge timeline and reads exc_seen at the end
 */
`timescale 1ns/1ns
`default_nettype none
module drs_exec_model (
	input  wire logic            clk,
	input  wire logic            fp_busy,
	input  wire logic            pgm_exc,
	output drs_pkg::drs_fp_req_t fp_req,
	output var int               exc_seen
);
	initial begin
		fp_req = '0;
		exc_seen = 0;
	end

	always @(posedge clk) begin
		if (pgm_exc === 1'b1) exc_seen++;
	end

	////////////////////////////////////////////////////////////////////////////////
	// operands come as whole aligned words, never split
	task automatic issue(input drs_pkg::drs_fp_op_t op, input logic lng, input logic [2:0] n,
		input logic [63:0] d);
		@(negedge clk);
		while (fp_busy !== 1'b0) @(negedge clk);
		fp_req = '{valid: 1'b1, op: op, long_fmt: lng, num: n, data: d};
		@(negedge clk);
		fp_req.valid = 1'b0;
	endtask
endmodule
`default_nettype wire

// ==== sim/tb_top.sv ====
/*
 * self-checking bench of the register stack against an integer and array model
 * assumes the execution control model in drs_exec_model and a 125 MHz clock
 */
`timescale 1ns/1ns
`default_nettype none
module tb_top;
	logic                 clk;
	logic                 rst;
	logic                 mode;
	logic [3:0]           ra;
	logic [3:0]           rb;
	drs_pkg::drs_gr_wr_t  gr_wr;
	drs_pkg::drs_fp_req_t fp_req;
	drs_pkg::drs_fp_rsp_t fp_rsp;
	logic                 wk_we;
	logic [2:0]           wk_idx;
	logic [63:0]          wk_wdata;
	logic                 reloc_we;
	logic [31:0]          reloc_wdata;
	logic [31:0]          ra_data, rb_data, reloc_cpu, reloc_chan;
	logic [63:0]          pair_data, wk_rdata;
	logic                 fp_busy, pgm_exc;
	int                   exc_seen, exc_exp;
	int                   err_total, checks_done;
	logic [31:0]          gr[2][16];
	logic [63:0]          fp[4];
	logic [63:0]          wk[8];

	drs_register_stack DUT (.CLK(clk), .RST(rst), .PROBLEM_MODE(mode), .GR_RA_IDX(ra), .GR_RB_IDX(rb),
		.GR_WR(gr_wr), .GR_RA_DATA(ra_data), .GR_RB_DATA(rb_data), .GR_PAIR_DATA(pair_data),
		.FP_REQ(fp_req), .FP_RSP(fp_rsp), .FP_BUSY(fp_busy), .PGM_EXC(pgm_exc), .WK_WE(wk_we),
		.WK_IDX(wk_idx), .WK_WDATA(wk_wdata), .WK_RDATA(wk_rdata), .RELOC_WE(reloc_we),
		.RELOC_WDATA(reloc_wdata), .RELOC_CPU(reloc_cpu), .RELOC_CHAN(reloc_chan));
	drs_exec_model u_exec (.clk(clk), .fp_busy(fp_busy), .pgm_exc(pgm_exc), .fp_req(fp_req),
		.exc_seen(exc_seen));

	initial begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end

	////////////////////////////////////////////////////////////////////////////////
	task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
		checks_done++;
		if (seen !== exp) begin
			err_total++;
			$display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	task automatic print_verdict();
		$display("checks=%0d mismatches=%0d", checks_done, err_total);
		if (err_total == 0 && checks_done > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask

	// every write also reads the same register in the same cycle, which must give the old value
	task automatic gr_write(input logic m, input drs_pkg::drs_gr_fmt_t f, input logic [3:0] i,
		input logic [63:0] d);
		logic [31:0] old;
		old = gr[m][i];
		@(negedge clk);
		mode = m;
		ra = i;
		gr_wr = '{en: 1'b1, fmt: f, idx: i, data: d};
		@(negedge clk);
		gr_wr.en = 1'b0;
		chk(64'(ra_data), 64'(old));
		case (f)
			drs_pkg::GW_HALF: gr[m][i] = {{16{d[15]}}, d[15:0]};
			drs_pkg::GW_DOUBLE: begin
				gr[m][i & 4'he] = d[63:32];
				gr[m][i | 4'h1] = d[31:0];
			end
			default: gr[m][i] = d[31:0];
		endcase
	endtask

	task automatic gr_read(input logic m, input logic [3:0] a, input logic [3:0] b);
		@(negedge clk);
		mode = m;
		ra = a;
		rb = b;
		@(negedge clk);
		chk(64'(ra_data), 64'(gr[m][a]));
		chk(64'(rb_data), 64'(gr[m][b]));
		chk(pair_data, {gr[m][a & 4'he], gr[m][a | 4'h1]});
	endtask

	function automatic logic [1:0] cmp(input logic [63:0] r, input logic [63:0] d);
		longint vr, vd;
		if (r[55:0] == 56'h0 && d[55:0] == 56'h0) return drs_pkg::CC_EQ;
		vr = r[63] ? -longint'(r[62:0]) : longint'(r[62:0]);
		vd = d[63] ? -longint'(d[62:0]) : longint'(d[62:0]);
		return (vr == vd) ? drs_pkg::CC_EQ : (vr < vd) ? drs_pkg::CC_LOW : drs_pkg::CC_HIGH;
	endfunction

	task automatic fp_do(input drs_pkg::drs_fp_op_t op, input logic lng, input logic [2:0] n,
		input logic [63:0] d);
		logic [63:0] v;
		logic [55:0] f;
		logic [6:0]  e;
		int          s, k;
		f = lng ? d[55:0] : {d[55:32], 32'h0};
		e = d[62:56];
		s = 0;
		if (f != 56'h0) while (f[55:52] == 4'h0) begin
			f = f << 4;
			e = e - 7'h1;
			s++;
		end
		u_exec.issue(op, lng, n, d);
		if (n[0]) exc_exp++;
		chk(64'(fp_busy), 64'(op == drs_pkg::FO_NORM_WB && !n[0]));
		k = 0;
		while (fp_rsp.done !== 1'b1 && k < 20) begin
			@(negedge clk);
			k++;
		end
		chk(64'(fp_rsp.done), 64'h1);
		chk(64'(k), (op == drs_pkg::FO_NORM_WB && !n[0]) ? 64'(s + 2) : 64'h0);
		chk(64'(pgm_exc), 64'(n[0]));
		chk(64'(fp_busy), 64'h0);
		if (op == drs_pkg::FO_COMPARE && !n[0]) chk(64'(fp_rsp.cc), 64'(cmp(fp[n[2:1]], d)));
		chk(fp_rsp.data, (op == drs_pkg::FO_STORE && !n[0]) ? fp[n[2:1]] : 64'h0);
		if (!n[0]) begin
			case (op)
				drs_pkg::FO_LPOS: v = {1'b0, d[62:0]};
				drs_pkg::FO_LNEG: v = {1'b1, d[62:0]};
				drs_pkg::FO_LCOMP: v = {~d[63], d[62:0]};
				drs_pkg::FO_NORM_WB: v = {d[63], e, f};
				default: v = d;
			endcase
			if (op != drs_pkg::FO_STORE && op != drs_pkg::FO_COMPARE) begin
				if (lng) fp[n[2:1]] = v;
				else fp[n[2:1]][63:32] = v[63:32];
			end
		end
	endtask

	task automatic fp_dump();
		for (int j = 0; j < 4; j++) fp_do(drs_pkg::FO_STORE, 1'b1, 3'(2 * j), 64'h0);
	endtask

	////////////////////////////////////////////////////////////////////////////////
	initial begin
		#(8 * 20000);
		err_total++;
		print_verdict();
	end

	initial begin
		logic [63:0] r;
		err_total = 0;
		checks_done = 0;
		exc_exp = 0;
		{rst, mode, ra, rb, gr_wr, wk_we, wk_idx, wk_wdata, reloc_we, reloc_wdata} = '0;
		rst = 1'b1;
		foreach (gr[m, i]) gr[m][i] = 32'h0;
		foreach (fp[j]) fp[j] = 64'h0;
		r = 64'($urandom(32'h182b));
		repeat (10) @(posedge clk);
		@(negedge clk);
		rst = 1'b0;
		chk({reloc_cpu, reloc_chan}, 64'h0);
		chk(64'({fp_busy, pgm_exc, fp_rsp.done}), 64'h0);
		// both banks, every index, random contents
		for (int m = 0; m < 2; m++)
			for (int i = 0; i < 16; i++)
				gr_write(1'(m), drs_pkg::GW_FULL, 4'(i), {$urandom, $urandom});
		for (int m = 0; m < 2; m++)
			for (int i = 0; i < 16; i++) gr_read(1'(m), 4'(i), 4'(15 - i));
		gr_write(1'b1, drs_pkg::GW_HALF, 4'h5, 64'h8001);
		gr_write(1'b0, drs_pkg::GW_HALF, 4'h6, 64'hffff_ffff_ffff_7fff);
		gr_write(1'b0, drs_pkg::GW_DOUBLE, 4'h9, {$urandom, $urandom});
		gr_write(1'b1, drs_pkg::GW_DOUBLE, 4'he, {$urandom, $urandom});
		gr_read(1'b1, 4'h5, 4'he);
		gr_read(1'b0, 4'h6, 4'h9);
		gr_read(1'b0, 4'h9, 4'h8);
		gr_read(1'b1, 4'hf, 4'h5);
		// working and relocation registers
		for (int i = 0; i < 8; i++) begin
			@(negedge clk);
			wk_we = 1'b1;
			wk_idx = 3'(i);
			wk[i] = {$urandom, $urandom};
			wk_wdata = wk[i];
		end
		@(negedge clk);
		wk_we = 1'b0;
		for (int i = 0; i < 8; i++) begin
			wk_idx = 3'(i);
			@(negedge clk);
			chk(wk_rdata, wk[i]);
		end
		reloc_we = 1'b1;
		reloc_wdata = $urandom;
		@(negedge clk);
		reloc_we = 1'b0;
		chk({reloc_cpu, reloc_chan}, {reloc_wdata, reloc_wdata});
		// floating loads on every number, then short and sign ops
		for (int n = 0; n < 8; n++) fp_do(drs_pkg::FO_LOAD, 1'b1, 3'(n), {$urandom, $urandom});
		fp_do(drs_pkg::FO_LOAD, 1'b0, 3'h2, {$urandom, $urandom});
		for (int o = 2; o < 5; o++)
			for (int l = 0; l < 2; l++)
				fp_do(drs_pkg::drs_fp_op_t'(o), 1'(l), 3'(2 * o - 4), {$urandom, $urandom});
		fp_dump();
		fp_do(drs_pkg::FO_LOAD, 1'b1, 3'h0, 64'h4210_0000_0000_0000);
		fp_do(drs_pkg::FO_COMPARE, 1'b1, 3'h0, 64'h4210_0000_0000_0000);
		fp_do(drs_pkg::FO_COMPARE, 1'b1, 3'h0, 64'hc210_0000_0000_0000);
		fp_do(drs_pkg::FO_COMPARE, 1'b1, 3'h0, 64'h4310_0000_0000_0000);
		// normalize: none, one, thirteen shifts, zero fraction, random
		fp_do(drs_pkg::FO_NORM_WB, 1'b1, 3'h0, 64'h4512_3456_789a_bcde);
		fp_do(drs_pkg::FO_NORM_WB, 1'b1, 3'h2, 64'hc101_2345_6789_abcd);
		fp_do(drs_pkg::FO_NORM_WB, 1'b1, 3'h4, 64'h0500_0000_0000_0007);
		fp_do(drs_pkg::FO_NORM_WB, 1'b1, 3'h6, 64'h8a00_0000_0000_0000);
		fp_do(drs_pkg::FO_NORM_WB, 1'b1, 3'h6, {$urandom, 8'h00, 24'($urandom >> 8)});
		// short writeback: three shifts, second word of the register kept
		fp_do(drs_pkg::FO_NORM_WB, 1'b0, 3'h2, 64'h4000_0123_dead_beef);
		fp_dump();
		fp_do(drs_pkg::FO_NORM_WB, 1'b1, 3'h3, 64'h4100_0000_0000_0001);
		fp_do(drs_pkg::FO_LOAD, 1'b0, 3'h7, 64'hffff_ffff_ffff_ffff);
		fp_dump();
		chk(64'(exc_seen), 64'(exc_exp));
		print_verdict();
	end
endmodule
`default_nettype wire
